//--- rtl/ls_unit_pkg.sv
// Constants and types shared by the load/store address unit
package ls_unit_pkg;

    localparam int DATA_W = 32;
    localparam int REG_IDX_W = 3;
    localparam int LOW_REG_COUNT = 8;
    localparam int IMM_W = 10;

    // Program counter seen by PC-relative forms, in bytes past the instruction
    localparam logic [31:0] PC_READ_AHEAD = 32'h0000_0004;
    localparam logic [31:0] WORD_STEP = 32'h0000_0004;

    // Immediate ranges in bytes
    localparam logic [IMM_W-1:0] PC_REL_IMM_MAX = 10'h3FC;
    localparam logic [IMM_W-1:0] SP_WORD_IMM_MAX = 10'h3FC;
    localparam logic [IMM_W-1:0] LOW_WORD_IMM_MAX = 10'h07C;
    localparam logic [IMM_W-1:0] HALF_IMM_MAX = 10'h03E;
    localparam logic [IMM_W-1:0] BYTE_IMM_MAX = 10'h01F;

    // Transfer size code on the data bus
    localparam logic [1:0] SIZE_BYTE = 2'h0;
    localparam logic [1:0] SIZE_HALF = 2'h1;
    localparam logic [1:0] SIZE_WORD = 2'h2;

    localparam logic [31:0] RESET_WORD = 32'h0000_0000;
    localparam logic [REG_IDX_W-1:0] RESET_REG = 3'h0;

    typedef enum logic [3:0] {
        ADDR_GEN_OP,
        LOAD_WORD_OP,
        LOAD_BYTE_OP,
        LOAD_HALF_OP,
        LOAD_SIGNED_BYTE_OP,
        LOAD_SIGNED_HALF_OP,
        LOAD_LITERAL_OP,
        STORE_WORD_OP,
        STORE_BYTE_OP,
        STORE_HALF_OP,
        LOAD_MULTIPLE_OP,
        STORE_MULTIPLE_OP
    } op_t;

endpackage

//--- rtl/ls_format_if.sv
// Carrier between the unit and its data formatter
`timescale 1ns/100ps
interface ls_format_if;
    logic [1:0] size;
    logic signedLoad;
    logic [31:0] storeIn;
    logic [31:0] storeOut;
    logic [31:0] loadIn;
    logic [31:0] loadOut;

    modport unit (output size, output signedLoad, output storeIn, output loadIn,
        input storeOut, input loadOut);
    modport formatter (input size, input signedLoad, input storeIn, input loadIn,
        output storeOut, output loadOut);
endinterface

//--- rtl/ls_format.sv
// Lane formatter: store narrowing and load zero/sign extension
`timescale 1ns/100ps
module ls_format
    import ls_unit_pkg::*;
(
    ls_format_if.formatter fmt
);

    always_comb begin
        case (fmt.size)
            SIZE_BYTE: fmt.storeOut = {24'h00_0000, fmt.storeIn[7:0]};
            SIZE_HALF: fmt.storeOut = {16'h0000, fmt.storeIn[15:0]};
            default: fmt.storeOut = fmt.storeIn;
        endcase
    end

    always_comb begin
        case (fmt.size)
            SIZE_BYTE: begin
                if (fmt.signedLoad) begin
                    fmt.loadOut = {{24{fmt.loadIn[7]}}, fmt.loadIn[7:0]};
                end else begin
                    fmt.loadOut = {24'h00_0000, fmt.loadIn[7:0]};
                end
            end
            SIZE_HALF: begin
                if (fmt.signedLoad) begin
                    fmt.loadOut = {{16{fmt.loadIn[15]}}, fmt.loadIn[15:0]};
                end else begin
                    fmt.loadOut = {16'h0000, fmt.loadIn[15:0]};
                end
            end
            default: fmt.loadOut = fmt.loadIn;
        endcase
    end

endmodule

//--- rtl/load_store_address_unit.sv
// Load/store and address-generation execution unit of a small 32-bit core
`timescale 1ns/100ps
module load_store_address_unit
    import ls_unit_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic issueValid,
    input op_t issueOp,
    input wire logic [REG_IDX_W-1:0] transferReg,
    input wire logic [REG_IDX_W-1:0] baseReg,
    input wire logic useStackBase,
    input wire logic useOffsetReg,
    input wire logic [IMM_W-1:0] immValue,
    input wire logic [LOW_REG_COUNT-1:0] regList,
    input wire logic writeBack,
    input wire logic [DATA_W-1:0] instrAddr,
    input wire logic [DATA_W-1:0] baseValue,
    input wire logic [DATA_W-1:0] stackValue,
    input wire logic [DATA_W-1:0] offsetValue,
    input wire logic [DATA_W-1:0] transferValue,
    output logic [REG_IDX_W-1:0] rfReadAddr_q,
    input wire logic [DATA_W-1:0] rfReadData,
    output logic rfWriteEn_q,
    output logic [REG_IDX_W-1:0] rfWriteAddr_q,
    output logic [DATA_W-1:0] rfWriteData_q,
    output logic busReq_q,
    output logic busWrite_q,
    output logic [1:0] busSize_q,
    output logic [DATA_W-1:0] busAddr_q,
    output logic [DATA_W-1:0] busWdata_q,
    input wire logic busReady,
    input wire logic [DATA_W-1:0] busRdata,
    output logic busyStall_q,
    output logic instrDone_q,
    output logic hardFaultReq_q,
    output logic flagsWriteEn_q
);

    typedef enum logic [2:0] {
        IDLE,
        SINGLE_ACCESS,
        MULTI_NEXT,
        MULTI_FETCH,
        MULTI_ACCESS
    } state_t;

    state_t state_q;
    logic isLoad_q;
    logic signedLoad_q;
    logic [REG_IDX_W-1:0] targetReg_q;
    logic [REG_IDX_W-1:0] multiBase_q;
    logic multiWriteBack_q;
    logic [LOW_REG_COUNT-1:0] pendingRegs_q;
    logic [DATA_W-1:0] writeBackValue_q;

    ls_format_if fmtBus();

    ls_format formatter (
        .fmt(fmtBus)
    );

    function automatic logic [1:0] sizeOf(input op_t op);
        case (op)
            LOAD_BYTE_OP, LOAD_SIGNED_BYTE_OP, STORE_BYTE_OP: sizeOf = SIZE_BYTE;
            LOAD_HALF_OP, LOAD_SIGNED_HALF_OP, STORE_HALF_OP: sizeOf = SIZE_HALF;
            default: sizeOf = SIZE_WORD;
        endcase
    endfunction

    function automatic logic isAligned(input logic [DATA_W-1:0] addr, input logic [1:0] size);
        case (size)
            SIZE_BYTE: isAligned = 1'b1;
            SIZE_HALF: isAligned = (addr[0] == 1'b0);
            default: isAligned = (addr[1:0] == 2'h0);
        endcase
    endfunction

    // Encodings outside the documented offset ranges are treated as faulting
    function automatic logic immLegal(input op_t op, input logic sp, input logic regOff,
        input logic [IMM_W-1:0] imm);
        case (op)
            ADDR_GEN_OP, LOAD_LITERAL_OP:
                immLegal = (imm <= PC_REL_IMM_MAX) && (imm[1:0] == 2'h0);
            LOAD_WORD_OP, STORE_WORD_OP:
                if (regOff) begin
                    immLegal = !sp;
                end else if (sp) begin
                    immLegal = (imm <= SP_WORD_IMM_MAX) && (imm[1:0] == 2'h0);
                end else begin
                    immLegal = (imm <= LOW_WORD_IMM_MAX) && (imm[1:0] == 2'h0);
                end
            LOAD_HALF_OP, STORE_HALF_OP:
                immLegal = !sp && (regOff || ((imm <= HALF_IMM_MAX) && (imm[0] == 1'b0)));
            LOAD_BYTE_OP, STORE_BYTE_OP:
                immLegal = !sp && (regOff || (imm <= BYTE_IMM_MAX));
            LOAD_SIGNED_BYTE_OP, LOAD_SIGNED_HALF_OP:
                immLegal = !sp && regOff;
            LOAD_MULTIPLE_OP, STORE_MULTIPLE_OP:
                immLegal = !sp;
            default: immLegal = 1'b0;
        endcase
    endfunction

    function automatic logic [REG_IDX_W-1:0] lowestSet(input logic [LOW_REG_COUNT-1:0] mask);
        lowestSet = RESET_REG;
        for (int i = LOW_REG_COUNT - 1; i >= 0; i--) begin
            if (mask[i]) begin
                lowestSet = REG_IDX_W'(i);
            end
        end
    endfunction

    function automatic logic [DATA_W-1:0] countWords(input logic [LOW_REG_COUNT-1:0] mask);
        countWords = RESET_WORD;
        for (int i = 0; i < LOW_REG_COUNT; i++) begin
            if (mask[i]) begin
                countWords = countWords + WORD_STEP;
            end
        end
    endfunction

    logic [DATA_W-1:0] pcValue;
    logic [DATA_W-1:0] baseSel;
    logic [DATA_W-1:0] offsetSel;
    logic [DATA_W-1:0] effAddr;
    logic [1:0] issueSize;
    logic issueIsLoad;
    logic issueLegal;
    logic [REG_IDX_W-1:0] nextReg;
    logic [LOW_REG_COUNT-1:0] nextRegBit;

    assign pcValue = instrAddr + PC_READ_AHEAD;
    // Only low registers are addressable: every register field is three bits wide
    assign baseSel = (issueOp == ADDR_GEN_OP || issueOp == LOAD_LITERAL_OP) ? pcValue :
        (useStackBase ? stackValue : baseValue);
    assign offsetSel = useOffsetReg ? offsetValue : {{(DATA_W-IMM_W){1'b0}}, immValue};
    assign effAddr = baseSel + offsetSel;
    assign issueSize = sizeOf(issueOp);
    assign issueIsLoad = (issueOp != STORE_WORD_OP) && (issueOp != STORE_BYTE_OP) &&
        (issueOp != STORE_HALF_OP) && (issueOp != STORE_MULTIPLE_OP);
    assign issueLegal = immLegal(issueOp, useStackBase, useOffsetReg, immValue);
    assign nextReg = lowestSet(pendingRegs_q);
    assign nextRegBit = LOW_REG_COUNT'(1) << nextReg;

    // Formatter sees the captured size while a single access is on the bus
    assign fmtBus.size = (state_q == IDLE) ? issueSize : busSize_q;
    assign fmtBus.signedLoad = signedLoad_q;
    assign fmtBus.storeIn = transferValue;
    assign fmtBus.loadIn = busRdata;

    // Sequencer
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            state_q <= IDLE;
        end else begin
            case (state_q)
                IDLE: begin
                    if (issueValid && issueLegal) begin
                        if (issueOp == LOAD_MULTIPLE_OP || issueOp == STORE_MULTIPLE_OP) begin
                            state_q <= MULTI_NEXT;
                        end else if (issueOp != ADDR_GEN_OP && isAligned(effAddr, issueSize)) begin
                            state_q <= SINGLE_ACCESS;
                        end
                    end
                end
                SINGLE_ACCESS: begin
                    if (busReady) begin
                        state_q <= IDLE;
                    end
                end
                MULTI_NEXT: begin
                    if (pendingRegs_q == '0 || !isAligned(busAddr_q, SIZE_WORD)) begin
                        state_q <= IDLE;
                    end else if (isLoad_q) begin
                        state_q <= MULTI_ACCESS;
                    end else begin
                        state_q <= MULTI_FETCH;
                    end
                end
                MULTI_FETCH: state_q <= MULTI_ACCESS;
                MULTI_ACCESS: begin
                    if (busReady) begin
                        state_q <= MULTI_NEXT;
                    end
                end
                default: state_q <= IDLE;
            endcase
        end
    end

    // Captured instruction context
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            isLoad_q <= 1'b0;
            signedLoad_q <= 1'b0;
            targetReg_q <= RESET_REG;
            multiBase_q <= RESET_REG;
            multiWriteBack_q <= 1'b0;
            writeBackValue_q <= RESET_WORD;
        end else if (state_q == IDLE && issueValid) begin
            isLoad_q <= issueIsLoad;
            signedLoad_q <= (issueOp == LOAD_SIGNED_BYTE_OP) || (issueOp == LOAD_SIGNED_HALF_OP);
            targetReg_q <= transferReg;
            multiBase_q <= baseReg;
            multiWriteBack_q <= writeBack;
            writeBackValue_q <= baseValue + countWords(regList);
        end
    end

    // Register list walk, lowest register first
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            pendingRegs_q <= '0;
            rfReadAddr_q <= RESET_REG;
        end else if (state_q == IDLE && issueValid) begin
            pendingRegs_q <= regList;
        end else if (state_q == MULTI_NEXT) begin
            rfReadAddr_q <= nextReg;
        end else if (state_q == MULTI_ACCESS && busReady) begin
            pendingRegs_q <= pendingRegs_q & ~nextRegBit;
        end
    end

    // Data bus master; request holds until the memory answers ready
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            busReq_q <= 1'b0;
            busWrite_q <= 1'b0;
            busSize_q <= SIZE_WORD;
            busAddr_q <= RESET_WORD;
            busWdata_q <= RESET_WORD;
        end else begin
            case (state_q)
                IDLE: begin
                    busAddr_q <= baseValue;
                    busSize_q <= issueSize;
                    busWrite_q <= !issueIsLoad;
                    if (issueValid && issueLegal && issueOp != ADDR_GEN_OP &&
                        issueOp != LOAD_MULTIPLE_OP && issueOp != STORE_MULTIPLE_OP) begin
                        busAddr_q <= effAddr;
                        busWdata_q <= fmtBus.storeOut;
                        busReq_q <= isAligned(effAddr, issueSize);
                    end
                end
                SINGLE_ACCESS: begin
                    if (busReady) begin
                        busReq_q <= 1'b0;
                    end
                end
                MULTI_NEXT: begin
                    busSize_q <= SIZE_WORD;
                    busReq_q <= isLoad_q && pendingRegs_q != '0 && isAligned(busAddr_q, SIZE_WORD);
                end
                MULTI_FETCH: begin
                    busWdata_q <= rfReadData;
                    busReq_q <= 1'b1;
                end
                MULTI_ACCESS: begin
                    if (busReady) begin
                        busReq_q <= 1'b0;
                        busAddr_q <= busAddr_q + WORD_STEP;
                    end
                end
                default: busReq_q <= 1'b0;
            endcase
        end
    end

    // Register file write port
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            rfWriteEn_q <= 1'b0;
            rfWriteAddr_q <= RESET_REG;
            rfWriteData_q <= RESET_WORD;
        end else begin
            rfWriteEn_q <= 1'b0;
            if (state_q == IDLE && issueValid && issueLegal && issueOp == ADDR_GEN_OP) begin
                rfWriteEn_q <= 1'b1;
                rfWriteAddr_q <= transferReg;
                rfWriteData_q <= effAddr;
            end else if (state_q == SINGLE_ACCESS && busReady && isLoad_q) begin
                rfWriteEn_q <= 1'b1;
                rfWriteAddr_q <= targetReg_q;
                rfWriteData_q <= fmtBus.loadOut;
            end else if (state_q == MULTI_ACCESS && busReady && isLoad_q) begin
                rfWriteEn_q <= 1'b1;
                rfWriteAddr_q <= nextReg;
                rfWriteData_q <= busRdata;
            end else if (state_q == MULTI_NEXT && pendingRegs_q == '0 && multiWriteBack_q) begin
                rfWriteEn_q <= 1'b1;
                rfWriteAddr_q <= multiBase_q;
                rfWriteData_q <= writeBackValue_q;
            end
        end
    end

    // Completion, stall and fault reporting
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            instrDone_q <= 1'b0;
            hardFaultReq_q <= 1'b0;
            busyStall_q <= 1'b0;
            flagsWriteEn_q <= 1'b0;
        end else begin
            flagsWriteEn_q <= 1'b0;
            instrDone_q <= 1'b0;
            hardFaultReq_q <= 1'b0;
            case (state_q)
                IDLE: begin
                    if (issueValid) begin
                        if (!issueLegal) begin
                            hardFaultReq_q <= 1'b1;
                            instrDone_q <= 1'b1;
                        end else if (issueOp == ADDR_GEN_OP) begin
                            instrDone_q <= 1'b1;
                        end else if (issueOp == LOAD_MULTIPLE_OP || issueOp == STORE_MULTIPLE_OP) begin
                            busyStall_q <= 1'b1;
                        end else if (!isAligned(effAddr, issueSize)) begin
                            hardFaultReq_q <= 1'b1;
                            instrDone_q <= 1'b1;
                        end else begin
                            busyStall_q <= 1'b1;
                        end
                    end
                end
                SINGLE_ACCESS: begin
                    if (busReady) begin
                        busyStall_q <= 1'b0;
                        instrDone_q <= 1'b1;
                    end
                end
                MULTI_NEXT: begin
                    if (!isAligned(busAddr_q, SIZE_WORD) && pendingRegs_q != '0) begin
                        busyStall_q <= 1'b0;
                        hardFaultReq_q <= 1'b1;
                        instrDone_q <= 1'b1;
                    end else if (pendingRegs_q == '0) begin
                        busyStall_q <= 1'b0;
                        instrDone_q <= 1'b1;
                    end
                end
                default: busyStall_q <= busyStall_q;
            endcase
        end
    end

endmodule

//--- test/ls_mem_model.sv
// Memory partner on the data bus: programmable wait states, address-derived read pattern
`timescale 1ns/100ps
module ls_mem_model (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic busReq_q,
    input wire logic busWrite_q,
    input wire logic [31:0] busAddr_q,
    input wire logic [3:0] waitCycles,
    output logic busReady,
    output logic [31:0] busRdata
);
    logic [3:0] waitCnt_q;
    logic [31:0] word;
    assign word = {busAddr_q[15:0], ~busAddr_q[15:0]};
    // Outside a completed read the lines carry the inverse, so a late sample never matches by luck
    assign busRdata = (busReady && !busWrite_q) ? word : ~word;
    initial busReady = 1'b0;
    always @(posedge core_clk) begin
        busReady <= 1'b0;
        waitCnt_q <= 4'h0;
        if (rst_n && busReq_q && !busReady) begin
            if (waitCnt_q == waitCycles) begin
                busReady <= 1'b1;
            end else begin
                waitCnt_q <= waitCnt_q + 4'h1;
            end
        end
    end
endmodule

//--- test/load_store_address_unit_sva.sv
// Port-level checks of the load/store address unit
`timescale 1ns/100ps
module load_store_address_unit_sva
    import ls_unit_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic issueValid,
    input op_t issueOp,
    input wire logic [REG_IDX_W-1:0] transferReg,
    input wire logic [IMM_W-1:0] immValue,
    input wire logic [DATA_W-1:0] instrAddr,
    input wire logic rfWriteEn_q,
    input wire logic [REG_IDX_W-1:0] rfWriteAddr_q,
    input wire logic [DATA_W-1:0] rfWriteData_q,
    input wire logic busReq_q,
    input wire logic busWrite_q,
    input wire logic [1:0] busSize_q,
    input wire logic [DATA_W-1:0] busAddr_q,
    input wire logic [DATA_W-1:0] busWdata_q,
    input wire logic busReady,
    input wire logic [DATA_W-1:0] busRdata,
    input wire logic busyStall_q,
    input wire logic instrDone_q,
    input wire logic hardFaultReq_q,
    input wire logic flagsWriteEn_q
);
    logic issueTook_q;
    logic issueTake;
    // A one-cycle op leaves busy low, so a still-held request must not count as a second issue
    assign issueTake = issueValid && !busyStall_q && !issueTook_q;
    always_ff @(posedge core_clk) begin
        issueTook_q <= rst_n && issueTake;
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    AST_FLAGS_KEPT: assert property (flagsWriteEn_q == 1'b0)
        else $error("condition flag write enabled");
    AST_FAULT_CLEAN: assert property (hardFaultReq_q |-> instrDone_q && !busReq_q && !rfWriteEn_q)
        else $error("fault without done or with an access");
    AST_ALIGNED: assert property (busReq_q |-> (busSize_q != SIZE_WORD || busAddr_q[1:0] == 2'h0) &&
        (busSize_q != SIZE_HALF || !busAddr_q[0]))
        else $error("misaligned bus access issued");
    AST_REQ_HOLD: assert property (busReq_q && !busReady |=> busReq_q && $stable(busAddr_q) &&
        $stable(busWrite_q) && $stable(busWdata_q))
        else $error("bus request changed before ready");
    AST_ADR_SUM: assert property (issueTake && issueOp == ADDR_GEN_OP && immValue[1:0] == 2'h0 |=>
        rfWriteEn_q && rfWriteAddr_q == $past(transferReg) &&
        rfWriteData_q == $past(instrAddr) + PC_READ_AHEAD + {22'h0, $past(immValue)})
        else $error("address generation result wrong");
    AST_PCREL_FAULT: assert property (issueTake && issueOp inside {ADDR_GEN_OP, LOAD_LITERAL_OP} &&
        immValue[1:0] != 2'h0 |=> hardFaultReq_q)
        else $error("unaligned pc-relative offset not refused");
    AST_LOAD_WRITES: assert property (busReq_q && busReady && !busWrite_q |=> rfWriteEn_q &&
        ($past(busSize_q) != SIZE_WORD || rfWriteData_q == $past(busRdata)))
        else $error("loaded word not written to register");
    AST_STORE_NARROW: assert property (busReq_q && busWrite_q |->
        (busSize_q != SIZE_BYTE || busWdata_q[31:8] == 24'h0) && (busSize_q != SIZE_HALF || busWdata_q[31:16] == 16'h0))
        else $error("narrow store data not right-justified");
    AST_BUSY_DONE: assert property ($fell(busyStall_q) |-> instrDone_q)
        else $error("stall ended without done");
endmodule
bind load_store_address_unit load_store_address_unit_sva load_store_address_unit_sva_i (.core_clk, .rst_n,
    .issueValid, .issueOp, .transferReg, .immValue, .instrAddr, .rfWriteEn_q, .rfWriteAddr_q, .rfWriteData_q,
    .busReq_q, .busWrite_q, .busSize_q, .busAddr_q, .busWdata_q, .busReady, .busRdata, .busyStall_q,
    .instrDone_q, .hardFaultReq_q, .flagsWriteEn_q);

//--- test/load_store_address_unit_bench.sv
// Self-checking bench: random instructions against a memory partner, results matched in order
`timescale 1ns/100ps
module load_store_address_unit_bench
    import ls_unit_pkg::*;
;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic issueValid = 1'b0;
    op_t issueOp = ADDR_GEN_OP;
    logic [2:0] transferReg = 3'h0, baseReg = 3'h0, rfReadAddr_q, rfWriteAddr_q;
    logic useStackBase = 1'b0, useOffsetReg = 1'b0, writeBack = 1'b0, keep = 1'b0;
    logic rfWriteEn_q, busReq_q, busWrite_q, busReady, busyStall_q, instrDone_q, hardFaultReq_q;
    logic [9:0] immValue = 10'h000;
    logic [7:0] regList = 8'h00;
    logic [31:0] instrAddr = 32'h0, baseValue = 32'h0, stackValue = 32'h0, offsetValue = 32'h0;
    logic [31:0] transferValue = 32'h0, rfReadData, rfWriteData_q, busAddr_q, busWdata_q, busRdata;
    logic [1:0] busSize_q;
    logic [3:0] waitCycles = 4'h0;
    logic [71:0] notes[$];
    int num_errors = 0;
    int checked = 0;
    logic [9:0] imms[10] = '{10'h000, 10'h3FC, 10'h3FD, 10'h07C, 10'h080, 10'h03E, 10'h03F, 10'h040, 10'h01F, 10'h020};
    assign rfReadData = {8{1'b1, rfReadAddr_q}};
    always #10 core_clk = ~core_clk;
    load_store_address_unit load_store_address_unit_i (.core_clk, .rst_n, .issueValid, .issueOp, .transferReg,
        .baseReg, .useStackBase, .useOffsetReg, .immValue, .regList, .writeBack, .instrAddr, .baseValue, .stackValue,
        .offsetValue, .transferValue, .rfReadAddr_q, .rfReadData, .rfWriteEn_q, .rfWriteAddr_q, .rfWriteData_q,
        .busReq_q, .busWrite_q, .busSize_q, .busAddr_q, .busWdata_q, .busReady, .busRdata, .busyStall_q,
        .instrDone_q, .hardFaultReq_q, .flagsWriteEn_q());
    ls_mem_model ls_mem_model_i (.core_clk, .rst_n, .busReq_q, .busWrite_q, .busAddr_q, .waitCycles, .busReady,
        .busRdata);
    task automatic give_verdict();
        if (notes.size() != 0) num_errors++;
        if (num_errors == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic compare(input logic [71:0] got);
        logic [71:0] exp;
        checked++;
        exp = (notes.size() > 0) ? notes.pop_front() : ~got;
        if (exp !== got) begin
            num_errors++;
            $display("ERROR at %0t: expected %h got %h", $time, exp, got);
        end
    endtask
    // Sampled mid-cycle so every flop and the partner have settled
    always @(negedge core_clk) begin
        if (rfWriteEn_q === 1'b1) compare({5'h00, rfWriteAddr_q, 32'h0, rfWriteData_q});
        if (busReq_q === 1'b1 && busReady === 1'b1)
            compare({5'h08, busWrite_q, busSize_q, busAddr_q, busWrite_q ? busWdata_q : 32'h0});
        if (hardFaultReq_q === 1'b1) compare({2'h2, 70'h0});
    end
    task automatic put(input logic [1:0] kind, input logic [5:0] f, input logic [31:0] a, input logic [31:0] d);
        notes.push_back({kind, f, a, d});
    endtask
    task automatic run();
        logic [31:0] pc, addr, d;
        logic [1:0] sz;
        logic bad, ld;
        int n;
        pc = instrAddr + PC_READ_AHEAD;
        ld = issueOp inside {[LOAD_WORD_OP:LOAD_LITERAL_OP]};
        sz = SIZE_WORD;
        if (issueOp inside {LOAD_BYTE_OP, LOAD_SIGNED_BYTE_OP, STORE_BYTE_OP}) sz = SIZE_BYTE;
        if (issueOp inside {LOAD_HALF_OP, LOAD_SIGNED_HALF_OP, STORE_HALF_OP}) sz = SIZE_HALF;
        addr = (useStackBase ? stackValue : baseValue) + (useOffsetReg ? offsetValue : {22'h0, immValue});
        bad = issueOp inside {LOAD_SIGNED_BYTE_OP, LOAD_SIGNED_HALF_OP} && !useOffsetReg;
        if (!useOffsetReg && sz == SIZE_WORD)
            bad = immValue[1:0] != 2'h0 || immValue > (useStackBase ? SP_WORD_IMM_MAX : LOW_WORD_IMM_MAX);
        if (!useOffsetReg && sz == SIZE_HALF) bad = bad || immValue[0] || immValue > HALF_IMM_MAX;
        if (!useOffsetReg && sz == SIZE_BYTE) bad = bad || immValue > BYTE_IMM_MAX;
        if (issueOp inside {ADDR_GEN_OP, LOAD_LITERAL_OP}) begin
            addr = pc + {22'h0, immValue};
            bad = immValue[1:0] != 2'h0;
        end
        if (issueOp inside {LOAD_MULTIPLE_OP, STORE_MULTIPLE_OP}) begin
            addr = baseValue & {32{|regList}};
            bad = 1'b0;
        end
        if (issueOp != ADDR_GEN_OP && (sz == SIZE_WORD ? addr[1:0] != 2'h0 : sz == SIZE_HALF && addr[0])) bad = 1'b1;
        if (bad) put(2'h2, 6'h0, 32'h0, 32'h0);
        else if (issueOp == ADDR_GEN_OP) put(2'h0, {3'h0, transferReg}, 32'h0, addr);
        else if (issueOp inside {LOAD_MULTIPLE_OP, STORE_MULTIPLE_OP}) begin
            n = 0;
            for (int i = 0; i < 8; i++) begin
                if (regList[i]) begin
                    d = (issueOp == STORE_MULTIPLE_OP) ? {8{1'b1, i[2:0]}} : 32'h0;
                    put(2'h1, {3'h0, issueOp == STORE_MULTIPLE_OP, SIZE_WORD}, addr + 32'(4 * n), d);
                    if (issueOp == LOAD_MULTIPLE_OP) put(2'h0, {3'h0, i[2:0]}, 32'h0, memWord(addr + 32'(4 * n)));
                    n++;
                end
            end
            if (writeBack) put(2'h0, {3'h0, baseReg}, 32'h0, baseValue + 32'(4 * n));
        end else begin
            d = transferValue;
            if (sz == SIZE_BYTE) d = {24'h0, transferValue[7:0]};
            if (sz == SIZE_HALF) d = {16'h0, transferValue[15:0]};
            put(2'h1, {3'h0, !ld, sz}, addr, ld ? 32'h0 : d);
            d = memWord(addr);
            case (issueOp)
                LOAD_BYTE_OP: d = {24'h0, d[7:0]};
                LOAD_HALF_OP: d = {16'h0, d[15:0]};
                LOAD_SIGNED_BYTE_OP: d = {{24{d[7]}}, d[7:0]};
                LOAD_SIGNED_HALF_OP: d = {{16{d[15]}}, d[15:0]};
                default: ;
            endcase
            if (ld) put(2'h0, {3'h0, transferReg}, 32'h0, d);
        end
        issueValid = 1'b1;
        @(posedge core_clk);
        #1;
        // Holding the request while busy must be ignored; kept to single transfers with known timing
        for (n = 0; n < 300 && instrDone_q !== 1'b1; n++) begin
            issueValid = keep && !bad && issueOp inside {[LOAD_WORD_OP:STORE_HALF_OP]};
            @(posedge core_clk);
            #1;
        end
        if (n == 300) begin
            num_errors++;
            give_verdict();
        end
    endtask
    function automatic logic [31:0] memWord(input logic [31:0] a);
        return {a[15:0], ~a[15:0]};
    endfunction
    initial begin
        void'($urandom(94));
        repeat (12) @(posedge core_clk);
        #1;
        rst_n = 1'b1;
        for (int k = 0; k < 500; k++) begin
            issueOp = op_t'(4'($urandom_range(11)));
            transferReg = 3'($urandom);
            baseReg = 3'($urandom);
            regList = ($urandom_range(7) == 0) ? 8'h00 : 8'($urandom);
            writeBack = 1'($urandom);
            instrAddr = {30'($urandom), ($urandom_range(7) == 0) ? 2'h2 : 2'h0};
            baseValue = $urandom & (($urandom_range(3) == 0) ? 32'hFFFFFFFF : 32'hFFFFFFFC);
            stackValue = $urandom & 32'hFFFFFFFC;
            offsetValue = $urandom & (($urandom_range(3) == 0) ? 32'hFFFFFFFF : 32'hFFFFFFFC);
            useOffsetReg = 1'($urandom) && !(issueOp inside {ADDR_GEN_OP, LOAD_LITERAL_OP, LOAD_MULTIPLE_OP, STORE_MULTIPLE_OP});
            useStackBase = !useOffsetReg && issueOp inside {LOAD_WORD_OP, STORE_WORD_OP} && 1'($urandom);
            immValue = 1'($urandom) ? imms[$urandom_range(9)] : 10'($urandom_range(127));
            transferValue = $urandom;
            waitCycles = 4'($urandom_range(3));
            keep = 1'($urandom);
            run();
        end
        issueValid = 1'b0;
        repeat (4) @(posedge core_clk);
        give_verdict();
    end
endmodule
